/* mpos_defs.vh */
// Offsets, fields and reset values of the phase output select block.
`ifndef MPOS_DEFS_VH
`define MPOS_DEFS_VH
// ============================================================
// Register byte offsets
`define MPOS_ADDR_PHASE_STATE 12'h000
`define MPOS_ADDR_PARITY 12'h004
`define MPOS_ADDR_CONTROL 12'h008
// ============================================================
// Phase state fields
`define MPOS_IS_HI 7
`define MPOS_IS_LO 6
`define MPOS_ON_HI 5
`define MPOS_ON_LO 0
// ============================================================
// Parity fields
`define MPOS_ZVD_BIT 7
`define MPOS_REO_BIT 6
`define MPOS_PAR_HI 5
`define MPOS_PAR_LO 0
// ============================================================
// Control fields
`define MPOS_CTL_MODE_HI 1
`define MPOS_CTL_MODE_LO 0
`define MPOS_CTL_STEP_BIT 2
`define MPOS_CTL_DRIVE_BIT 3
`define MPOS_CTL_SENSOR_BIT 4
`define MPOS_CTL_DIRECT_BIT 5
`define MPOS_CTL_POL_HI 13
`define MPOS_CTL_POL_LO 8
// ============================================================
// Encodings and reset values
`define MPOS_MODE_EVEN 2'h0
`define MPOS_MODE_ODD 2'h1
`define MPOS_MODE_ALT 2'h2
`define MPOS_MODE_ALL 2'h3
`define MPOS_SEL_A 2'h0
`define MPOS_SEL_B 2'h1
`define MPOS_SEL_C 2'h2
`define MPOS_RESET_BYTE 8'h00
`define MPOS_RESET_CTL 14'h0000
`endif

/* mpos_phase_output_select.v */
// Phase output select, comparator routing and parity logic.
// ============================================================
// Overview of operation
// R1 - Select 0, 1, 2 feeds phase A, B, C to the comparator; 3 is unused.
// R2 - On bits apply at commutation, or at once under direct access.
// R3 - An on bit of 0 holds the channel off; 1 turns it on, PWM possible.
// R4 - Select and on bits wait in preload until the next commutation.
// R5 - Edge relation 0 means opposite zero and demag edges, 1 the same edge.
// R6 - Read parity 0 samples back-EMF off time on even channels, 1 on odd.
// R7 - Each channel parity bit marks the channel even at 0 and odd at 1.
// R8 - After demag, output mode picks even, odd, alternate or all channels.
// R9 - Before demag when sensorless, drive and step option pick the PWM set.
// R10 - Under direct access a phase write loads all preloads at once.
// R11 - A read of a preloaded register returns the working value.
// R12 - Each pin combines its on bit with its polarity bit.
// R13 - Phase state and parity registers and preloads reset to zero.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "mpos_defs.vh"
module mpos_phase_output_select (
	input wire sys_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire commutationEvent,
	input wire demagEvent,
	input wire pwmIn,
	input wire phaseInputA,
	input wire phaseInputB,
	input wire phaseInputC,
	output reg comparatorInput,
	output reg zeroDemagEdgeRelation,
	output reg bemfSampleWindow,
	output reg [5:0] motorOutputPins
);

// ============================================================
// Register storage
// Preloads take the phase state, parity and step option writes; working copies drive the logic and the reads.
reg [7:0] phaseStatePre;
reg [7:0] phaseState;
reg [7:0] parityPre;
reg [7:0] parity;
reg [13:0] control;
reg stepOptionPre;
reg stepOption;
reg afterDemag;
reg altPhase;
reg [2:0] phaseSync;
reg [2:0] phaseMeta;
reg pwmSync;
reg pwmMeta;

wire [1:0] pwmOutputMode = control[`MPOS_CTL_MODE_HI:`MPOS_CTL_MODE_LO];
wire voltageCurrentDrive = control[`MPOS_CTL_DRIVE_BIT];
wire sensorModeSelect = control[`MPOS_CTL_SENSOR_BIT];
wire directAccess = control[`MPOS_CTL_DIRECT_BIT];
wire [5:0] channelPolarityBits = control[`MPOS_CTL_POL_HI:`MPOS_CTL_POL_LO];
wire [1:0] comparatorInputSelect = phaseState[`MPOS_IS_HI:`MPOS_IS_LO];
wire [5:0] channelOnBits = phaseState[`MPOS_ON_HI:`MPOS_ON_LO];
wire [5:0] channelOdd = parity[`MPOS_PAR_HI:`MPOS_PAR_LO];
wire bemfReadParity = parity[`MPOS_REO_BIT];

wire apbWrite = psel && penable && pwrite;
wire hitPhase = (paddr == `MPOS_ADDR_PHASE_STATE);
wire hitParity = (paddr == `MPOS_ADDR_PARITY);
wire hitControl = (paddr == `MPOS_ADDR_CONTROL);
// Unmapped addresses answer with an error and change nothing.
wire hitAny = hitPhase || hitParity || hitControl;
wire phaseWrite = apbWrite && hitPhase;
wire parityWrite = apbWrite && hitParity;
wire controlWrite = apbWrite && hitControl;
wire setupPhase = psel && !penable;
wire readSetup = setupPhase && !pwrite;
// Direct access loads on the phase write itself, using the new write data.
wire directLoad = phaseWrite && directAccess; // [R10]
wire loadWorking = commutationEvent || directLoad; // [R2] [R4]

// ============================================================
// Read data selection
// Reads show the working copies, since those are what drive the pins.
reg [31:0] nextReadData;
always @* begin
	if (hitPhase) begin
		nextReadData = {24'h000000, phaseState}; // [R11]
	end else if (hitParity) begin
		nextReadData = {24'h000000, parity}; // [R11]
	end else if (hitControl) begin
		nextReadData = {18'h00000, control[13:3], stepOption,
			control[1:0]};
	end else begin
		nextReadData = 32'h00000000;
	end
end

// ============================================================
// APB slave, zero wait states
always @(posedge sys_clk) begin
	if (!rstn) begin
		phaseStatePre <= `MPOS_RESET_BYTE; // [R13]
		parityPre <= `MPOS_RESET_BYTE; // [R13]
		control <= `MPOS_RESET_CTL;
		stepOptionPre <= 1'b0;
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		// The answer is prepared in the setup cycle, so no wait states.
		pready <= setupPhase;
		pslverr <= setupPhase && !hitAny;
		if (phaseWrite) begin
			phaseStatePre <= pwdata[7:0];
		end
		if (parityWrite) begin
			parityPre <= pwdata[7:0];
		end
		if (controlWrite) begin
			control <= pwdata[13:0];
			stepOptionPre <= pwdata[`MPOS_CTL_STEP_BIT];
		end
		if (readSetup) begin
			prdata <= nextReadData; // [R11]
		end
	end
end

// ============================================================
// Working phase state
// Direct access takes the bus data itself, on the same edge that the preload takes it.
always @(posedge sys_clk) begin
	if (!rstn) begin
		phaseState <= `MPOS_RESET_BYTE; // [R13]
	end else if (directLoad) begin
		phaseState <= pwdata[7:0]; // [R10]
	end else if (loadWorking) begin
		phaseState <= phaseStatePre; // [R4]
	end
end

// ============================================================
// Working parity and step option
// A direct load also moves these, so all preloads change together.
always @(posedge sys_clk) begin
	if (!rstn) begin
		parity <= `MPOS_RESET_BYTE; // [R13]
	end else if (loadWorking) begin
		parity <= parityPre; // [R10]
	end
end

always @(posedge sys_clk) begin
	if (!rstn) begin
		stepOption <= 1'b0;
	end else if (loadWorking) begin
		stepOption <= stepOptionPre;
	end
end

// ============================================================
// Step phase tracking
// Demagnetisation seen in the same cycle as commutation is ignored,
// since the new step has only just begun.
always @(posedge sys_clk) begin
	if (!rstn) begin
		afterDemag <= 1'b0;
		altPhase <= 1'b0;
	end else begin
		if (commutationEvent) begin
			afterDemag <= 1'b0;
			altPhase <= ~altPhase;
		end else if (demagEvent) begin
			afterDemag <= 1'b1;
		end
	end
end

// ============================================================
// Phase input synchroniser
// Only the second stage is read, so a metastable first stage stays local.
always @(posedge sys_clk) begin
	if (!rstn) begin
		phaseMeta <= 3'h0;
		phaseSync <= 3'h0;
	end else begin
		phaseMeta <= {phaseInputC, phaseInputB, phaseInputA};
		phaseSync <= phaseMeta;
	end
end

// ============================================================
// PWM level synchroniser
// The PWM level comes from another timing source, so it is synchronised too.
always @(posedge sys_clk) begin
	if (!rstn) begin
		pwmMeta <= 1'b0;
		pwmSync <= 1'b0;
	end else begin
		pwmMeta <= pwmIn;
		pwmSync <= pwmMeta;
	end
end

// ============================================================
// PWM set after demagnetisation
// An empty set keeps active channels on solid, which is continuous drive.
// Alternation follows the commutation count, not time.
wire continuousMode = !sensorModeSelect && !voltageCurrentDrive && !stepOption;
wire [5:0] alternateSet = altPhase ? channelOdd : ~channelOdd;
reg [5:0] afterSet;
always @* begin
	case (pwmOutputMode) // [R8]
	`MPOS_MODE_EVEN: afterSet = ~channelOdd; // [R7]
	`MPOS_MODE_ODD: afterSet = channelOdd;
	`MPOS_MODE_ALT: begin
		if (continuousMode) begin
			afterSet = 6'h00;
		end else begin
			afterSet = alternateSet;
		end
	end
	default: afterSet = 6'h3F;
	endcase
end

// ============================================================
// PWM set before demagnetisation
reg [5:0] beforeSet;
always @* begin
	if (!stepOption) begin // [R9]
		beforeSet = voltageCurrentDrive ? ~channelOdd : afterSet;
	end else if (!voltageCurrentDrive) begin
		beforeSet = alternateSet;
	end else begin
		beforeSet = channelOdd;
	end
end

// ============================================================
// Active PWM set
// Sensor mode has no pre-demagnetisation phase, so it always uses afterSet.
reg [5:0] pwmSet;
always @* begin
	if (sensorModeSelect || afterDemag) begin
		pwmSet = afterSet;
	end else begin
		pwmSet = beforeSet;
	end
end

// ============================================================
// Comparator input selection
// Code 3 gives a quiet low, so a stray select cannot toggle the comparator.
reg nextComparator;
always @* begin
	case (comparatorInputSelect) // [R1]
	`MPOS_SEL_A: nextComparator = phaseSync[0];
	`MPOS_SEL_B: nextComparator = phaseSync[1];
	`MPOS_SEL_C: nextComparator = phaseSync[2];
	default: nextComparator = 1'b0;
	endcase
end

// ============================================================
// Output pins, one per channel
// Direct access gives plain logic levels: no PWM is applied then.
// Polarity 0 makes a channel active low, so reset leaves every pin high.
genvar ch;
generate
	for (ch = 0; ch < 6; ch = ch + 1) begin : genChannel
		wire chanOn = channelOnBits[ch] &&
			(directAccess || !pwmSet[ch] || pwmSync); // [R3]
		always @(posedge sys_clk) begin
			if (!rstn) begin
				motorOutputPins[ch] <= 1'b1;
			end else begin
				motorOutputPins[ch] <= ~(chanOn ^
					channelPolarityBits[ch]); // [R12]
			end
		end
	end
endgenerate

// ============================================================
// Comparator routing and sampling window
// Only a modulated channel shows back-EMF during the off time.
wire [5:0] readParitySet = bemfReadParity ? channelOdd : ~channelOdd;
wire [5:0] sampleChannels = channelOnBits & pwmSet & readParitySet;
always @(posedge sys_clk) begin
	if (!rstn) begin
		comparatorInput <= 1'b0;
		zeroDemagEdgeRelation <= 1'b0;
		bemfSampleWindow <= 1'b0;
	end else begin
		comparatorInput <= nextComparator; // [R1]
		zeroDemagEdgeRelation <= parity[`MPOS_ZVD_BIT]; // [R5]
		bemfSampleWindow <= !pwmSync && (|sampleChannels); // [R6]
	end
end

endmodule

/* mpos_bridge.sv */
// Bridge and back-EMF sensing partner of the phase output select block.
`timescale 1ns/1ps
module mpos_bridge (
	input wire sys_clk,
	input wire [1:0] pwmMode,
	input wire [2:0] bemfLevels,
	output reg pwmIn = 1'b0,
	output reg [2:0] phaseIn = 3'h0
);
	reg [2:0] cnt = 3'h0;
	// ============================================================
	// Mode 2 runs a free PWM, so pin logic never sees a frozen level.
	always @(posedge sys_clk) begin
		cnt <= cnt + 3'h1;
		pwmIn <= pwmMode[1] ? cnt[2] : pwmMode[0];
		phaseIn <= bemfLevels;
	end
endmodule

/* mpos_pos_sva.sv */
// Port checker of the phase output select block.
`timescale 1ns/1ps
module mpos_pos_sva (
	input wire sys_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire commutationEvent,
	input wire pwmIn,
	input wire zeroDemagEdgeRelation,
	input wire bemfSampleWindow,
	input wire [5:0] motorOutputPins
);
	wire acc = psel & penable;
	// ============================================================
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_ready_access: assert property (acc |-> pready)
		else $error("no ready in access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_unmapped_err: assert property (psel && !penable && paddr > 12'h008
		|=> pslverr)
		else $error("no error on unmapped");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_pins_reset: assert property (disable iff (1'b0)
		!rstn |=> motorOutputPins == 6'h3F)
		else $error("pins not off in reset");
	a_edge_reset: assert property (disable iff (1'b0)
		!rstn |=> !zeroDemagEdgeRelation)
		else $error("edge bit not cleared");
	a_edge_cause: assert property ($changed(zeroDemagEdgeRelation) |->
		$past(commutationEvent, 2) || $past(commutationEvent) ||
		$past(acc, 2) || $past(acc))
		else $error("edge bit moved alone");
	a_window_pwm: assert property (bemfSampleWindow |->
		!$past(pwmIn, 3))
		else $error("window while pwm high");
endmodule
bind mpos_phase_output_select mpos_pos_sva chk (.sys_clk(sys_clk),
	.rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr),
	.commutationEvent(commutationEvent), .pwmIn(pwmIn),
	.zeroDemagEdgeRelation(zeroDemagEdgeRelation),
	.bemfSampleWindow(bemfSampleWindow),
	.motorOutputPins(motorOutputPins));

/* mpos_phase_output_select_tb.sv */
// Self-checking bench of the phase output select block.
`timescale 1ns/1ps
module mpos_phase_output_select_tb;
	reg sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	reg pwrite = 1'b0, commutationEvent = 1'b0, demagEvent = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, lfsr = 32'hF416;
	reg [1:0] pwmMode = 2'h1;
	reg [2:0] bemfLevels = 3'h0;
	wire [31:0] prdata;
	wire [5:0] motorOutputPins;
	wire [2:0] phaseIn;
	wire pready, pslverr, pwmIn, comparatorInput, zeroDemagEdgeRelation;
	wire bemfSampleWindow;
	int bad_count = 0, tests_run = 0;
	reg [31:0] expQ[$];
	reg [5:0] aft = 6'h00;
	bit alt = 1'b0;
	mpos_phase_output_select uut (.sys_clk(sys_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .commutationEvent(commutationEvent),
		.demagEvent(demagEvent), .pwmIn(pwmIn), .phaseInputA(phaseIn[0]),
		.phaseInputB(phaseIn[1]), .phaseInputC(phaseIn[2]),
		.comparatorInput(comparatorInput),
		.zeroDemagEdgeRelation(zeroDemagEdgeRelation),
		.bemfSampleWindow(bemfSampleWindow),
		.motorOutputPins(motorOutputPins));
	mpos_bridge partner (.sys_clk(sys_clk), .pwmMode(pwmMode),
		.bemfLevels(bemfLevels), .pwmIn(pwmIn), .phaseIn(phaseIn));
	// ============================================================
	initial forever #4 sys_clk = ~sys_clk;
	function automatic [31:0] nextRand(input [31:0] v);
		nextRand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input [31:0] s, input [31:0] e, input string n);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input [11:0] a, input w, input [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input [11:0] a, input [31:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask
	// Five edges cover the two-flop input sync plus the output register.
	task automatic settle;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic pins(input [5:0] e);
		settle;
		check(32'(motorOutputPins), 32'(e), "pins");
	endtask
	task automatic pulse(input c);
		@(posedge sys_clk);
		commutationEvent <= c;
		demagEvent <= !c;
		if (c) alt = !alt;
		@(posedge sys_clk);
		commutationEvent <= 1'b0;
		demagEvent <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ============================================================
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite)
			check(prdata, expQ.pop_front(), "prdata");
		if (psel && penable && pready)
			check(32'(pslverr), 32'(paddr > 12'h008), "pslverr");
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h00C, 32'h0);
		pins(6'h3F);
		apb(12'h000, 1'b1, 32'h3F);
		rd(12'h000, 32'h0);
		pulse(1'b1);
		rd(12'h000, 32'h3F);
		pins(6'h00);
		$display("preload test done");
		pwmMode <= 2'h0;
		for (int m = 0; m < 4; m += 1 + (m == 1)) begin
			apb(12'h008, 1'b1, 32'h10 | m);
			pulse(1'b1);
			pulse(1'b0);
			pins(m == 1 ? 6'h00 : 6'h3F);
			check(32'(bemfSampleWindow), 32'(m != 1), "window");
		end
		$display("mode test done");
		pwmMode <= 2'h2;
		for (int i = 0; i < 8; i++) begin
			lfsr = nextRand(lfsr);
			apb(12'h008, 1'b1, {18'h0, lfsr[13:8], 8'h20});
			apb(12'h000, 1'b1, {26'h0, lfsr[5:0]});
			pins(~(lfsr[5:0] ^ lfsr[13:8]));
		end
		rd(12'h000, {26'h0, lfsr[5:0]});
		$display("direct test done");
		for (int s = 0; s < 4; s++) begin
			bemfLevels <= (s == 3) ? 3'h7 : 3'h1 << s;
			apb(12'h000, 1'b1, 32'(s << 6));
			settle;
			check(32'(comparatorInput), 32'(s != 3), "comp");
		end
		apb(12'h004, 1'b1, 32'h80);
		apb(12'h000, 1'b1, 32'h0);
		settle;
		check(32'(zeroDemagEdgeRelation), 32'h1, "edge");
		rd(12'h004, 32'h80);
		$display("select test done");
		pwmMode <= 2'h0;
		apb(12'h004, 1'b1, 32'h55);
		apb(12'h000, 1'b1, 32'h3F);
		for (int k = 0; k < 4; k++) begin
			apb(12'h008, 1'b1, 32'(k << 2 | 2));
			pulse(1'b1);
			aft = (k == 0) ? 6'h00 : alt ? 6'h15 : 6'h2A;
			pins(k == 2 ? 6'h2A : k == 3 ? 6'h15 : aft);
			pulse(1'b0);
			pins(aft);
			check(32'(bemfSampleWindow), 32'(|(aft & 6'h15)), "window");
		end
		$display("sensorless test done");
		print_verdict;
	end
endmodule
